// [core/monitor_cfg.v]
// Configuration register and shunt result register of a current monitor.
// Assumes a serial protocol engine in front that presents decoded byte
// reads and writes on CORE_CLK, and an analog front end giving samples.
//
// Functional notes
// RULE_01 - Writing top bit resets all, self-clears
// RULE_02 - Bit 13 selects 16V or 32V range
// RULE_03 - Bits 12:11 select shunt gain, reset /8
// RULE_04 - Bits 10:7 set bus conversion resolution/averaging
// RULE_05 - Bits 6:3 set shunt conversion resolution/averaging
// RULE_06 - Top bit zero: single 9-12 bit conversion
// RULE_07 - Top bit one: 12-bit or 2-128 averaged
// RULE_08 - Mode field resets to both continuous
// RULE_09 - Mode codes decode to eight operating modes
// RULE_10 - Sign bits count follows gain setting
// RULE_11 - Negative readings two's complement, sign extended
// RULE_12 - Gain /8 full scale 7D00h, 8300h
// RULE_13 - Gain /4 3E80h; /2 1F40h, E0C0h
// RULE_14 - Unity gain full scale 0FA0h
// RULE_15 - Registers move most significant byte first
// RULE_16 - Host waits 4 us before readback
// RULE_17 - Bit 14 stored but has no effect
// RULE_18 - Triggered mode converts once per write
`timescale 1ns/100ps
`default_nettype none
`include "monitor_cfg_map.vh"

module monitor_cfg #(
  parameter SAMPLE_W = 16
) (
  input  wire                CORE_CLK,
  input  wire                RST_N,
  input  wire [7:0]          PTR,
  input  wire                WR_MSB,
  input  wire                WR_LSB,
  input  wire [7:0]          WR_DATA,
  input  wire                RD_MSB,
  input  wire                RD_LSB,
  output reg  [7:0]          RD_DATA,
  input  wire [SAMPLE_W-1:0] SHUNT_SAMPLE,
  input  wire [SAMPLE_W-1:0] BUS_SAMPLE,
  output reg  [15:0]         BUS_RESULT,
  output reg                 BUS_RANGE_32V,
  output reg  [1:0]          SHUNT_GAIN_SELECT,
  output reg                 SHUNT_BUSY,
  output reg                 BUS_BUSY,
  output reg                 SOFT_RESET
);

  // Conversion lengths in clock cycles, kept 32 bits wide and cut on use.
  localparam [31:0] CYC_9  = `T9_US * `CLK_MHZ;
  localparam [31:0] CYC_10 = `T10_US * `CLK_MHZ;
  localparam [31:0] CYC_11 = `T11_US * `CLK_MHZ;
  localparam [31:0] CYC_12 = `T12_US * `CLK_MHZ;

  // --------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------
  // Conversion time in clock cycles for one converter setting.
  function [22:0] conv_cycles;
    input [3:0] setting;
    reg   [22:0] one;
    begin
      case (setting[1:0])
        2'h0:    one = CYC_9[22:0];
        2'h1:    one = CYC_10[22:0];
        2'h2:    one = CYC_11[22:0];
        default: one = CYC_12[22:0];
      endcase
      if (setting[3]) begin
        one = CYC_12[22:0];
        conv_cycles = one << setting[2:0]; // [RULE_07]
      end else begin
        conv_cycles = one; // [RULE_06]
      end
    end
  endfunction

  // Clamps a reading to the gain range; in-range readings pass unchanged.
  function [15:0] shunt_format;
    input [15:0] raw;
    input [1:0]  gain;
    reg   [15:0] fs;
    begin
      case (gain)
        `GAIN_1: fs = `FS_GAIN_1; // [RULE_14]
        `GAIN_2: fs = `FS_GAIN_2; // [RULE_13]
        `GAIN_4: fs = `FS_GAIN_4; // [RULE_13]
        default: fs = `FS_GAIN_8; // [RULE_12]
      endcase
      if (!raw[15] && raw > fs)
        shunt_format = fs; // [RULE_10]
      else if (raw[15] && (~raw + 16'h0001) > fs)
        shunt_format = ~fs + 16'h0001; // [RULE_11]
      else
        shunt_format = raw;
    end
  endfunction

  // --------------------------------------------------------------------
  // Configuration register
  // --------------------------------------------------------------------
  reg  [15:0] config_reg;
  reg  [7:0]  msb_hold;
  reg  [15:0] shunt_result;
  reg         trig_pend;
  wire        cfg_write = WR_LSB && (PTR == `PTR_CONFIG);
  wire [15:0] cfg_word  = {msb_hold, WR_DATA};
  wire        do_reset  = cfg_write && cfg_word[`CFG_RESET_BIT];
  wire [2:0]  mode      = config_reg[`CFG_MODE_HI:`CFG_MODE_LO];
  wire [1:0]  gain      = config_reg[`CFG_GAIN_HI:`CFG_GAIN_LO];

  always @(posedge CORE_CLK) begin
    if (!RST_N || SOFT_RESET) begin
      config_reg <= `CONFIG_RESET; // [RULE_08]
      msb_hold   <= 8'h00;
      trig_pend  <= 1'b0;
    end else begin
      if (WR_MSB)
        msb_hold <= WR_DATA; // [RULE_15]
      if (cfg_write && !do_reset) begin
        // Bit 15 reads back zero; bit 14 is plain storage.
        config_reg <= cfg_word & `CONFIG_WMASK; // [RULE_17]
        trig_pend  <= 1'b1; // [RULE_18]
      end else begin
        trig_pend <= 1'b0;
      end
    end
  end

  // Soft reset pulses one cycle and loads reset values into every register except RD_DATA. [RULE_01]
  always @(posedge CORE_CLK) begin
    if (!RST_N)
      SOFT_RESET <= 1'b0;
    else
      SOFT_RESET <= do_reset; // [RULE_01]
  end

  always @(posedge CORE_CLK) begin
    if (!RST_N || SOFT_RESET) begin
      BUS_RANGE_32V     <= 1'b1;
      SHUNT_GAIN_SELECT <= `GAIN_8;
    end else begin
      BUS_RANGE_32V     <= config_reg[`CFG_RANGE_BIT]; // [RULE_02]
      SHUNT_GAIN_SELECT <= gain; // [RULE_03]
    end
  end

  // --------------------------------------------------------------------
  // Conversion sequencing
  // --------------------------------------------------------------------
  reg  [22:0] sh_cnt;
  reg  [22:0] bus_cnt;
  wire        sh_en  = mode[0] && mode != `MODE_CONV_OFF; // [RULE_09]
  wire        bus_en = mode[1]; // [RULE_09]
  wire        cont   = mode[2]; // [RULE_09]

  always @(posedge CORE_CLK) begin
    if (!RST_N || SOFT_RESET) begin
      sh_cnt       <= 23'h000000;
      bus_cnt      <= 23'h000000;
      SHUNT_BUSY   <= 1'b0;
      BUS_BUSY     <= 1'b0;
      shunt_result <= 16'h0000;
      BUS_RESULT   <= 16'h0000;
    end else begin
      // Shunt converter. [RULE_05]
      if (!sh_en) begin
        SHUNT_BUSY <= 1'b0;
      end else if (SHUNT_BUSY) begin
        if (sh_cnt == 23'h000001) begin
          shunt_result <= shunt_format(SHUNT_SAMPLE[15:0], gain);
          SHUNT_BUSY   <= cont;
          sh_cnt <= conv_cycles(config_reg[`CFG_SHCNV_HI:`CFG_SHCNV_LO]);
        end else begin
          sh_cnt <= sh_cnt - 23'h000001;
        end
      end else if (cont || trig_pend) begin
        SHUNT_BUSY <= 1'b1; // [RULE_18]
        sh_cnt <= conv_cycles(config_reg[`CFG_SHCNV_HI:`CFG_SHCNV_LO]);
      end
      // Bus converter. [RULE_04]
      if (!bus_en) begin
        BUS_BUSY <= 1'b0;
      end else if (BUS_BUSY) begin
        if (bus_cnt == 23'h000001) begin
          BUS_RESULT <= BUS_SAMPLE[15:0];
          BUS_BUSY   <= cont;
          bus_cnt <= conv_cycles(config_reg[`CFG_BUSCNV_HI:`CFG_BUSCNV_LO]);
        end else begin
          bus_cnt <= bus_cnt - 23'h000001;
        end
      end else if (cont || trig_pend) begin
        BUS_BUSY <= 1'b1; // [RULE_18]
        bus_cnt <= conv_cycles(config_reg[`CFG_BUSCNV_HI:`CFG_BUSCNV_LO]);
      end
    end
  end

  // --------------------------------------------------------------------
  // Read path
  // --------------------------------------------------------------------
  reg [15:0] rd_word;
  always @* begin
    case (PTR)
      `PTR_CONFIG: rd_word = config_reg;
      `PTR_SHUNT:  rd_word = shunt_result;
      default:     rd_word = 16'h0000;
    endcase
  end

  always @(posedge CORE_CLK) begin
    if (!RST_N)
      RD_DATA <= 8'h00;
    else if (RD_MSB)
      RD_DATA <= rd_word[15:8]; // [RULE_15]
    else if (RD_LSB)
      RD_DATA <= rd_word[7:0]; // [RULE_15]
  end

endmodule
`default_nettype wire

// [core/monitor_cfg_map.vh]
// Constants for the monitor configuration and shunt result block.
// Assumes inclusion by its bare name from design and bench files.
`ifndef MONITOR_CFG_MAP_VH
`define MONITOR_CFG_MAP_VH

// ----------------------------------------------------------------------
// Register pointers and reset values
// ----------------------------------------------------------------------
`define PTR_CONFIG        8'h00
`define PTR_SHUNT         8'h01
`define CONFIG_RESET      16'h399f
`define CONFIG_WMASK      16'h7fff

// ----------------------------------------------------------------------
// Configuration field positions
// ----------------------------------------------------------------------
`define CFG_RESET_BIT     15
`define CFG_SPARE_BIT     14
`define CFG_RANGE_BIT     13
`define CFG_GAIN_HI       12
`define CFG_GAIN_LO       11
`define CFG_BUSCNV_HI     10
`define CFG_BUSCNV_LO     7
`define CFG_SHCNV_HI      6
`define CFG_SHCNV_LO      3
`define CFG_MODE_HI       2
`define CFG_MODE_LO       0

// ----------------------------------------------------------------------
// Gain codes and shunt full-scale limits in 10 uV counts
// ----------------------------------------------------------------------
`define GAIN_1            2'h0
`define GAIN_2            2'h1
`define GAIN_4            2'h2
`define GAIN_8            2'h3
`define FS_GAIN_1         16'h0fa0
`define FS_GAIN_2         16'h1f40
`define FS_GAIN_4         16'h3e80
`define FS_GAIN_8         16'h7d00

// ----------------------------------------------------------------------
// Operating modes
// ----------------------------------------------------------------------
`define MODE_POWER_DOWN   3'h0
`define MODE_SHUNT_TRIG   3'h1
`define MODE_BUS_TRIG     3'h2
`define MODE_BOTH_TRIG    3'h3
`define MODE_CONV_OFF     3'h4
`define MODE_SHUNT_CONT   3'h5
`define MODE_BUS_CONT     3'h6
`define MODE_BOTH_CONT    3'h7

// ----------------------------------------------------------------------
// Conversion times in microseconds and clock rate
// ----------------------------------------------------------------------
`define CLK_MHZ           50
`define T9_US             84
`define T10_US            148
`define T11_US            276
`define T12_US            532

`endif

// [dv/monitor_cfg_props.sv]
// Port assertions for the monitor configuration block.
// Assumes one clock domain with a synchronous active-low reset.
`timescale 1ns/100ps
`default_nettype none
module monitor_cfg_props (
  input wire logic       CORE_CLK,
  input wire logic       RST_N,
  input wire logic [7:0] PTR,
  input wire logic       WR_LSB,
  input wire logic       RD_MSB,
  input wire logic [7:0] RD_DATA,
  input wire logic       BUS_RANGE_32V,
  input wire logic [1:0] SHUNT_GAIN_SELECT,
  input wire logic       SHUNT_BUSY,
  input wire logic       BUS_BUSY,
  input wire logic       SOFT_RESET
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RST_N);
  a_reset_fields: assert property (
    $rose(RST_N) |-> BUS_RANGE_32V && SHUNT_GAIN_SELECT == 2'h3)
    else $error("range or gain off after reset");
  a_busy_start: assert property (
    $rose(RST_N) |-> !SHUNT_BUSY ##1 (SHUNT_BUSY && BUS_BUSY))
    else $error("no conversion after reset");
  a_soft_pulse: assert property (SOFT_RESET |=> !SOFT_RESET)
    else $error("soft reset pulse too long");
  a_soft_cause: assert property (
    $rose(SOFT_RESET) |-> $past(WR_LSB) && $past(PTR) == 8'h00)
    else $error("soft reset without config write");
  a_soft_value: assert property (
    SOFT_RESET |-> ##[1:3] (BUS_RANGE_32V && SHUNT_GAIN_SELECT == 2'h3))
    else $error("soft reset left fields set");
  a_gain_cause: assert property (
    $changed(SHUNT_GAIN_SELECT) |-> $past(WR_LSB) || $past(WR_LSB, 2)
      || $past(SOFT_RESET) || $past(SOFT_RESET, 2))
    else $error("gain moved without write");
  a_range_cause: assert property (
    $changed(BUS_RANGE_32V) |-> $past(WR_LSB) || $past(WR_LSB, 2)
      || $past(SOFT_RESET) || $past(SOFT_RESET, 2))
    else $error("range moved without write");
  a_unmapped_read: assert property (
    RD_MSB && PTR > 8'h01 |=> RD_DATA == 8'h00)
    else $error("unmapped read not zero");
  c_soft: cover property (SOFT_RESET);
  c_shunt_done: cover property ($fell(SHUNT_BUSY));
  c_gain_move: cover property ($changed(SHUNT_GAIN_SELECT));
endmodule
bind monitor_cfg monitor_cfg_props u_props (
  .CORE_CLK(CORE_CLK), .RST_N(RST_N), .PTR(PTR), .WR_LSB(WR_LSB),
  .RD_MSB(RD_MSB), .RD_DATA(RD_DATA), .BUS_RANGE_32V(BUS_RANGE_32V),
  .SHUNT_GAIN_SELECT(SHUNT_GAIN_SELECT), .SHUNT_BUSY(SHUNT_BUSY),
  .BUS_BUSY(BUS_BUSY), .SOFT_RESET(SOFT_RESET));
`default_nettype wire

// [dv/host_model.sv]
// Host side model issuing byte-wide register reads and writes.
// Assumes a decoded protocol engine; drives on the falling clock edge.
`timescale 1ns/100ps
`default_nettype none
module host_model (
  input  wire logic       CORE_CLK,
  input  wire logic [7:0] RD_DATA,
  output var  logic [7:0] PTR,
  output var  logic       WR_MSB,
  output var  logic       WR_LSB,
  output var  logic [7:0] WR_DATA,
  output var  logic       RD_MSB,
  output var  logic       RD_LSB
);
  initial begin
    {PTR, WR_MSB, WR_LSB, WR_DATA, RD_MSB, RD_LSB} = '0;
  end
  task automatic wr16(input logic [7:0] p, input logic [15:0] d);
    @(negedge CORE_CLK);
    PTR = p;
    WR_DATA = d[15:8];
    WR_MSB = 1'b1;
    @(negedge CORE_CLK);
    WR_MSB = 1'b0;
    WR_DATA = d[7:0];
    WR_LSB = 1'b1;
    @(negedge CORE_CLK);
    WR_LSB = 1'b0;
    WR_DATA = ~d[7:0];
  endtask
  task automatic rd16(input logic [7:0] p, output logic [15:0] d);
    @(negedge CORE_CLK);
    PTR = p;
    RD_MSB = 1'b1;
    @(negedge CORE_CLK);
    RD_MSB = 1'b0;
    RD_LSB = 1'b1;
    d[15:8] = RD_DATA;
    @(negedge CORE_CLK);
    RD_LSB = 1'b0;
    d[7:0] = RD_DATA;
  endtask
endmodule
`default_nettype wire

// [dv/test_monitor_cfg.sv]
// Self-checking bench for the monitor configuration block.
// Assumes the host model and checker are compiled before this file.
`timescale 1ns/100ps
`default_nettype none
`include "monitor_cfg_map.vh"
module test_monitor_cfg;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [7:0]  ptr, wd, rd;
  logic        wm, wl, rm, rl, r32, sb, bb, sr;
  logic [1:0]  gs;
  logic [15:0] shs = 16'h0, bss = 16'h0, bres, rv, fs, e;
  int          n_errors = 0, checked = 0, g, k;
  always #10 clk = ~clk;
  host_model host (.CORE_CLK(clk), .RD_DATA(rd), .PTR(ptr), .WR_MSB(wm),
    .WR_LSB(wl), .WR_DATA(wd), .RD_MSB(rm), .RD_LSB(rl));
  monitor_cfg dut (.CORE_CLK(clk), .RST_N(rst_n), .PTR(ptr), .WR_MSB(wm),
    .WR_LSB(wl), .WR_DATA(wd), .RD_MSB(rm), .RD_LSB(rl), .RD_DATA(rd),
    .SHUNT_SAMPLE(shs), .BUS_SAMPLE(bss), .BUS_RESULT(bres),
    .BUS_RANGE_32V(r32), .SHUNT_GAIN_SELECT(gs), .SHUNT_BUSY(sb),
    .BUS_BUSY(bb), .SOFT_RESET(sr));
  task automatic check(input logic [15:0] seen, exp, input string what);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic results;
    $display("mismatches %0d comparisons %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic wait_busy(input logic lvl, input int lim);
    int i;
    for (i = 0; i < lim && (sb | bb) !== lvl; i++)
      @(negedge clk);
    if (i == lim) begin
      n_errors++;
      results();
    end
  endtask
  initial begin
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
    host.rd16(`PTR_CONFIG, rv);
    check(rv, `CONFIG_RESET, "config");
    host.wr16(`PTR_CONFIG, 16'h4924);
    repeat (200) @(negedge clk);
    host.rd16(`PTR_CONFIG, rv);
    check(rv, 16'h4924, "config");
    check({15'h0, r32}, 16'h0, "range");
    check({14'h0, gs}, `GAIN_2, "gain");
    host.rd16(8'h05, rv);
    check(rv, 16'h0, "unmapped");
    for (g = 0; g < 4; g++) begin
      fs = g == 0 ? `FS_GAIN_1 : g == 1 ? `FS_GAIN_2 :
        g == 2 ? `FS_GAIN_4 : `FS_GAIN_8;
      for (k = 0; k < 3; k++) begin
        shs = k == 0 ? 16'h7fff : k == 1 ? 16'h8000 : 16'hfffe;
        e = k == 0 ? fs : k == 1 ? -fs : shs;
        bss = {g[7:0], k[7:0]};
        host.wr16(`PTR_CONFIG, {3'h1, g[1:0], 8'h00, `MODE_BOTH_TRIG});
        wait_busy(1'b1, 8);
        wait_busy(1'b0, 6000);
        host.rd16(`PTR_SHUNT, rv);
        check(rv, e, "shunt");
        check(bres, bss, "bus result");
      end
    end
    host.wr16(`PTR_CONFIG, {3'h1, `GAIN_8, 4'h0, 4'h4, `MODE_SHUNT_TRIG});
    wait_busy(1'b1, 8);
    for (k = 0; k < 9000 && sb === 1'b1; k++)
      @(negedge clk);
    check(k[15:0], `T9_US * `CLK_MHZ, "shunt time");
    check({15'h0, bb}, 16'h0, "bus idle");
    host.wr16(`PTR_CONFIG, 16'h8000);
    repeat (200) @(negedge clk);
    host.rd16(`PTR_CONFIG, rv);
    check(rv, `CONFIG_RESET, "soft reset");
    results();
  end
endmodule
`default_nettype wire
